// ==== src/sol_strap_latch.sv ====
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module sol_strap_latch
    import sol_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire sol_pins_t i_pin_in,
    output sol_pins_t o_pin_out,
    output sol_pins_t o_pin_oe,
    input wire sol_pins_t i_func_out,
    output sol_cfg_t o_cfg,
    output sol_link_t o_link,
    output logic o_straps_valid,
    input wire logic [SOL_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [SOL_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ******************************
    // helpers
    // ******************************
    function automatic logic mode_mdix(input logic [2:0] m);
        return (m == SOL_MODE_MDIX_A) || (m == SOL_MODE_MDIX_B);
    endfunction

    function automatic logic mode_rsvd(input logic [2:0] m);
        return (m != SOL_MODE_RST) && !mode_mdix(m);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s, input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (s[0])
            v[7:0] = d[7:0];
        if (s[1])
            v[15:8] = d[15:8];
        return (v & mask) | (old & ~mask);
    endfunction

    // ******************************
    // strap capture
    // ******************************
    sol_pins_t pin_sync;
    logic [1:0] settle_reg;
    logic latched_reg;
    logic latch_pulse;
    logic [4:0] addr_reg;
    logic [2:0] mode_reg;
    logic gate_test_reg;
    logic filter_off_reg;
    logic addr0_unique_reg;

    // async pins: reset-time level cannot be taken under the async reset itself
    sol_sync #(
        .WIDTH(SOL_PIN_W)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_async(i_pin_in),
        .o_sync(pin_sync)
    );

    // wait for the synchroniser to fill before the one-shot capture
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            settle_reg <= '0;
        else if (!latched_reg && settle_reg != SOL_SETTLE_CYCLES)
            settle_reg <= settle_reg + 2'h1;
    end

    assign latch_pulse = !latched_reg && (settle_reg == SOL_SETTLE_CYCLES);

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            latched_reg <= 1'b0;
        else if (latch_pulse)
            latched_reg <= 1'b1;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            addr_reg <= SOL_ADDR_RST;
            mode_reg <= SOL_MODE_RST;
            gate_test_reg <= 1'b0;
            filter_off_reg <= 1'b0;
            addr0_unique_reg <= 1'b0;
        end
        else if (latch_pulse)
        begin
            addr_reg <= {2'b00, pin_sync.rxd[1], pin_sync.rxd[2], pin_sync.rxd[3]};
            mode_reg <= {pin_sync.rxdv, pin_sync.crs, pin_sync.rxc};
            gate_test_reg <= !pin_sync.irq_out;
            filter_off_reg <= pin_sync.rxer;
            addr0_unique_reg <= pin_sync.col;
        end
    end

    always_comb
    begin
        o_cfg.mgmt_address_strap = addr_reg;
        o_cfg.mode = mode_reg;
        o_cfg.auto_mdix = mode_mdix(mode_reg);
        o_cfg.mode_reserved = mode_rsvd(mode_reg);
        o_cfg.gate_test = gate_test_reg;
        o_cfg.line_filter_off_strap = filter_off_reg;
        o_cfg.addr0_unique_strap = addr0_unique_reg;
        o_cfg.addr0_bcast = !addr0_unique_reg;
    end

    assign o_straps_valid = latched_reg;

    // ******************************
    // pin turnaround
    // ******************************
    sol_pins_t pin_out_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pin_out_reg <= '0;
        else
            pin_out_reg <= i_func_out;
    end

    assign o_pin_out = pin_out_reg;
    // drive only after capture, so a strap is never fought by our own output
    assign o_pin_oe = {SOL_PIN_W{latched_reg}};

    // ******************************
    // software registers
    // ******************************
    logic [15:0] ctrl_reg;
    logic [15:0] adv_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [SOL_ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic do_write;

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (do_write)
            aw_hold_reg <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            w_hold_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end
        else if (do_write)
            w_hold_reg <= 1'b0;
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= SOL_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (aw_addr_reg == SOL_CTRL_OFS || aw_addr_reg == SOL_ADV_OFS
                          || aw_addr_reg == SOL_STAT_OFS) ? SOL_RESP_OKAY : SOL_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    // strap capture takes precedence over a write in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            ctrl_reg <= SOL_CTRL_RST;
        else if (latch_pulse)
        begin
            ctrl_reg <= SOL_CTRL_RST & ~SOL_CTRL_WMASK;
            ctrl_reg[SOL_CTRL_AN_BIT] <= pin_sync.indicator_a;
            ctrl_reg[SOL_CTRL_SPEED_BIT] <= pin_sync.indicator_b;
            ctrl_reg[SOL_CTRL_DUPLEX_BIT] <= !pin_sync.rxd[0];
        end
        else if (do_write && aw_addr_reg == SOL_CTRL_OFS)
            ctrl_reg <= merge16(ctrl_reg, w_data_reg, w_strb_reg, SOL_CTRL_WMASK);
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            adv_reg <= SOL_ADV_RST;
        else if (latch_pulse)
        begin
            adv_reg[SOL_ADV_100FD_BIT] <= pin_sync.indicator_b;
            adv_reg[SOL_ADV_100HD_BIT] <= pin_sync.indicator_b;
        end
        else if (do_write && aw_addr_reg == SOL_ADV_OFS)
            adv_reg <= merge16(adv_reg, w_data_reg, w_strb_reg, SOL_ADV_WMASK);
    end

    // forced link settings used when auto-negotiation is off
    always_comb
    begin
        o_link.an_en = ctrl_reg[SOL_CTRL_AN_BIT];
        o_link.speed100 = ctrl_reg[SOL_CTRL_SPEED_BIT];
        o_link.full_duplex = ctrl_reg[SOL_CTRL_DUPLEX_BIT];
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ******************************
    // read channel
    // ******************************
    assign s_axi_arready = !rvalid_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= SOL_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg <= SOL_RESP_OKAY;
            unique case (s_axi_araddr)
                SOL_CTRL_OFS: rdata_reg <= {16'h0000, ctrl_reg};
                SOL_ADV_OFS: rdata_reg <= {16'h0000, adv_reg};
                SOL_STAT_OFS: rdata_reg <= {16'h0000, 1'b0, latched_reg, o_cfg};
                default:
                begin
                    rdata_reg <= '0;
                    rresp_reg <= SOL_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ******************************
    // checks
    // ******************************
    a_addr_upper_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        addr_reg[4:3] == 2'b00)
        else $error("management address upper bits not zero");

    a_addr_capture: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        latch_pulse |=> addr_reg[2:0] == {$past(pin_sync.rxd[1]), $past(pin_sync.rxd[2]), $past(pin_sync.rxd[3])})
        else $error("management address not taken from straps");

    a_straps_hold: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        latched_reg ##1 latched_reg |-> $stable(o_cfg))
        else $error("latched strap values changed");

    a_oe_in_reset: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !latched_reg |-> o_pin_oe == '0 ##1 (latched_reg || o_pin_oe == '0))
        else $error("strap pin driven before capture");

    a_oe_after_latch: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        latch_pulse |=> o_pin_oe == {SOL_PIN_W{1'b1}})
        else $error("strap pin not driven after capture");

    a_mode_mdix_map: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        o_cfg.auto_mdix == (mode_reg == 3'h2 || mode_reg == 3'h6))
        else $error("auto crossover mode decode wrong");

    a_mode_reserved: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        o_cfg.mode_reserved == (mode_reg inside {3'h1, 3'h3, 3'h4, 3'h5, 3'h7}))
        else $error("reserved mode decode wrong");

    a_duplex_invert: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        latch_pulse |=> ctrl_reg[8] == !$past(pin_sync.rxd[0]))
        else $error("duplex strap not inverted into control");

    a_speed_advert: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        latch_pulse |=> ctrl_reg[13] == adv_reg[8] && adv_reg[7] == adv_reg[8])
        else $error("speed strap not mirrored into advertisement");

    a_bcast_addr0: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        latch_pulse |=> o_cfg.addr0_bcast == !$past(pin_sync.col))
        else $error("address zero broadcast handling wrong");

    a_test_mode: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        latch_pulse |=> gate_test_reg == !$past(pin_sync.irq_out))
        else $error("gate-chain test mode strap wrong");

endmodule // sol_strap_latch

// ==== src/sol_pkg.sv ====
package sol_pkg;

    // ******************************
    // register map, byte addresses
    // ******************************
    localparam logic [3:0] SOL_CTRL_OFS = 4'h0;
    localparam logic [3:0] SOL_ADV_OFS = 4'h4;
    localparam logic [3:0] SOL_STAT_OFS = 4'h8;
    localparam int SOL_ADDR_W = 4;

    // ******************************
    // field positions
    // ******************************
    localparam int SOL_CTRL_SPEED_BIT = 13;
    localparam int SOL_CTRL_AN_BIT = 12;
    localparam int SOL_CTRL_DUPLEX_BIT = 8;
    localparam int SOL_ADV_100FD_BIT = 8;
    localparam int SOL_ADV_100HD_BIT = 7;

    // ******************************
    // values after reset, write masks and mode codes
    // ******************************
    localparam logic [15:0] SOL_CTRL_RST = 16'h3000;
    localparam logic [15:0] SOL_CTRL_WMASK = 16'h3100;
    localparam logic [15:0] SOL_ADV_RST = 16'h01e1;
    localparam logic [15:0] SOL_ADV_WMASK = 16'h01e0;
    localparam logic [4:0] SOL_ADDR_RST = 5'h01;
    localparam logic [2:0] SOL_MODE_RST = 3'h0;
    localparam logic [2:0] SOL_MODE_MDIX_A = 3'h2;
    localparam logic [2:0] SOL_MODE_MDIX_B = 3'h6;

    // ******************************
    // counts and bus response codes
    // ******************************
    localparam int SOL_SYNC_STAGES = 2;
    localparam logic [1:0] SOL_SETTLE_CYCLES = 2'h3;
    localparam logic [1:0] SOL_RESP_OKAY = 2'h0;
    localparam logic [1:0] SOL_RESP_SLVERR = 2'h2;

    // ******************************
    // carriers
    // ******************************
    localparam int SOL_PIN_W = 12;

    typedef struct packed {
        logic col;
        logic rxer;
        logic irq_out;
        logic indicator_b;
        logic indicator_a;
        logic rxc;
        logic crs;
        logic rxdv;
        logic [3:0] rxd;
    } sol_pins_t;

    typedef struct packed {
        logic [4:0] mgmt_address_strap;
        logic [2:0] mode;
        logic auto_mdix;
        logic mode_reserved;
        logic gate_test;
        logic line_filter_off_strap;
        logic addr0_unique_strap;
        logic addr0_bcast;
    } sol_cfg_t;

    typedef struct packed {
        logic an_en;
        logic speed100;
        logic full_duplex;
    } sol_link_t;

endpackage

// ==== src/sol_sync.sv ====
`timescale 1ns/100ps
module sol_sync
    import sol_pkg::*;
#(
    parameter int WIDTH = SOL_PIN_W
)
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // refused at elaboration, a zero-width synchroniser cannot carry a pin
    if (WIDTH < 1)
    begin : g_width_check
        $error("sol_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule // sol_sync

// ==== test/sol_pull_model.sv ====
`timescale 1ns/100ps
// ******************************
// board pulls and mac pins
// ******************************
module sol_pull_model
    import sol_pkg::*;
(
    input wire sol_pins_t i_board,
    input wire sol_pins_t i_dev_out,
    input wire sol_pins_t i_dev_oe,
    output sol_pins_t o_pin
);
    // released bits fall back to the board resistor, never to the last driven value
    assign o_pin = sol_pins_t'((i_dev_out & i_dev_oe) | (i_board & ~i_dev_oe));
endmodule // sol_pull_model

// ==== test/tb_strap_option_latch.sv ====
`timescale 1ns/100ps
module tb_strap_option_latch
    import sol_pkg::*;
;
    // ******************************
    // signals
    // ******************************
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    sol_pins_t board = '0;
    sol_pins_t func = '0;
    sol_pins_t pin_in, pin_out, pin_oe;
    sol_cfg_t cfg;
    sol_link_t link;
    logic valid;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fail_count = 0;
    int num_checks = 0;
    integer seed = 32'h59a81bda;

    always #50 i_sys_clk = ~i_sys_clk;

    sol_pull_model i_board (.i_board(board), .i_dev_out(pin_out), .i_dev_oe(pin_oe), .o_pin(pin_in));

    sol_strap_latch i_dut (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_pin_in(pin_in), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .i_func_out(func), .o_cfg(cfg), .o_link(link), .o_straps_valid(valid),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    // ******************************
    // expectations
    // ******************************
    function automatic sol_cfg_t exp_cfg(input sol_pins_t p);
        sol_cfg_t c;
        c.mgmt_address_strap = {2'h0, p.rxd[1], p.rxd[2], p.rxd[3]};
        c.mode = {p.rxdv, p.crs, p.rxc};
        c.auto_mdix = (c.mode == 3'h2) || (c.mode == 3'h6);
        c.mode_reserved = (c.mode != 3'h0) && !c.auto_mdix;
        c.gate_test = !p.irq_out;
        c.line_filter_off_strap = p.rxer;
        c.addr0_unique_strap = p.col;
        c.addr0_bcast = !p.col;
        return c;
    endfunction

    function automatic logic [15:0] exp_ctrl(input sol_pins_t p);
        return {2'h0, p.indicator_b, p.indicator_a, 3'h0, !p.rxd[0], 8'h00};
    endfunction

    function automatic logic [15:0] exp_adv(input sol_pins_t p);
        return {7'h00, p.indicator_b, p.indicator_b, 2'h3, 5'h01};
    endfunction

    // ******************************
    // compare and finish
    // ******************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ******************************
    // bus master
    // ******************************
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge i_sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_t)
        begin
            @(negedge i_sys_clk);
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t = s_axi_wvalid & s_axi_wready;
            b_t = s_axi_bvalid & s_axi_bready;
            r = s_axi_bresp;
            @(posedge i_sys_clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        r_t = 1'b0;
        @(posedge i_sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_t)
        begin
            @(negedge i_sys_clk);
            ar_t = s_axi_arvalid & s_axi_arready;
            r_t = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge i_sys_clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    // ******************************
    // main sequence
    // ******************************
    initial
    begin
        logic [31:0] rnd, d;
        logic [1:0] r;
        sol_cfg_t held;
        for (int k = 0; k < 14; k++)
        begin
            @(posedge i_sys_clk);
            rnd = $random(seed);
            // first pass leaves only the default pulls on the board
            if (k == 0)
                board <= sol_pins_t'(12'h389);
            else if (k <= 8)
                board <= sol_pins_t'({rnd[11:7], 3'(k - 1), rnd[3:0]});
            else
                board <= sol_pins_t'(rnd[11:0]);
            i_arst_n <= 1'b0;
            repeat (16) @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            chk({20'h0, pin_oe}, 32'h0);
            chk({31'h0, valid}, 32'h0);
            chk({27'h0, cfg.mgmt_address_strap}, {27'h0, SOL_ADDR_RST});
            @(posedge i_sys_clk);
            i_arst_n <= 1'b1;
            while (valid !== 1'b1) @(negedge i_sys_clk);
            chk({18'h0, cfg}, {18'h0, exp_cfg(board)});
            chk({20'h0, pin_oe}, 32'hfff);
            chk({29'h0, link}, {29'h0, board.indicator_a, board.indicator_b, !board.rxd[0]});
            held = cfg;
            axi_read(SOL_CTRL_OFS, d, r);
            chk(d, {16'h0, exp_ctrl(board)});
            axi_read(SOL_ADV_OFS, d, r);
            chk(d, {16'h0, exp_adv(board)});
            axi_read(SOL_STAT_OFS, d, r);
            chk(d, {17'h0, 1'b1, exp_cfg(board)});
            // device now drives the pins, so the strap inputs see functional traffic
            for (int n = 0; n < 4; n++)
            begin
                @(posedge i_sys_clk);
                rnd = $random(seed);
                func <= sol_pins_t'(rnd[11:0]);
                @(posedge i_sys_clk);
                @(negedge i_sys_clk);
                chk({20'h0, pin_out}, {20'h0, func});
                chk({18'h0, cfg}, {18'h0, held});
            end
            rnd = $random(seed);
            axi_write(SOL_CTRL_OFS, rnd, r);
            chk_resp(r, SOL_RESP_OKAY);
            @(negedge i_sys_clk);
            chk({29'h0, link}, {29'h0, rnd[12], rnd[13], rnd[8]});
            axi_read(SOL_CTRL_OFS, d, r);
            chk(d, {16'h0, rnd[15:0] & SOL_CTRL_WMASK});
            axi_write(SOL_ADV_OFS, rnd, r);
            axi_read(SOL_ADV_OFS, d, r);
            chk(d, {16'h0, (rnd[15:0] & SOL_ADV_WMASK) | 16'h0001});
            axi_write(SOL_STAT_OFS, 32'h0, r);
            axi_read(SOL_STAT_OFS, d, r);
            chk(d, {17'h0, 1'b1, held});
            axi_write(4'hc, rnd, r);
            chk_resp(r, SOL_RESP_SLVERR);
            axi_read(4'hc, d, r);
            chk_resp(r, SOL_RESP_SLVERR);
            chk(d, 32'h0);
        end
        stop_test();
    end

    // ******************************
    // watchdog
    // ******************************
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        stop_test();
    end
endmodule // tb_strap_option_latch
